/* File: common/pcms_pkg.sv */
// constants for the pam clock and missing-pulse sync block
// assumes a 25 MHz system clock and a sampled video amplitude input
//
// Overview of operation
// R1 - clock out as square wave and pulse; data sync as pulse, both phase locked
// R2 - data sync is clock delayed to land at minimum crosstalk
// R3 - outputs keep running through up to about 30 missing data pulses
// R4 - recovery stops after more than about 30 consecutive missing pulses
// R5 - each clock rising half starts 4..25 us delay ending in one sync pulse
// R6 - square wave, sync pulses and edge clock pulses go to their consumers
// R7 - one missing-pulse flag per clock period lacking its data pulse
// R8 - pulse absent when amplitude under 0.5 V above baseline at sampling; code also treats a pulse seen earlier in the slot as present
// R9 - each recovered clock edge makes one buffer reset pulse per period
// R10 - absence strobe delayed 4..25 us after clock, centred on data pulse
// R11 - detector fires on every absent pulse only; feeds register and selector
// R12 - register keeps flags eight periods; gives direct and delayed flag
// R13 - nine flip-flop chain: one input buffer then eight storage stages
// R14 - buffer holds arriving flag until next clock moves it onward
// R15 - buffer loads while clock low; storage captures on clock rising
// R16 - absent flag stores the opposite state; each clock shifts all stages
// R17 - register outputs delayed and direct flags to coincidence logic
// R18 - downstream pulse only when direct and delayed flags coincide
// R19 - nominal recovered clock period is one 25 us channel slot
// R20 - count consecutive missing pulses, clear on detected pulse
// R21 - recovery resumes once data pulses are detected again
package pcms_pkg;
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned PERIOD_NS       = 25000;
	localparam int unsigned PERIOD_CYC      = PERIOD_NS / (1000000000 / CLK_HZ);
	localparam int unsigned DELAY_MIN_NS    = 4000;
	localparam int unsigned DELAY_MAX_NS    = 25000;
	localparam int unsigned DELAY_MIN_CYC   = (DELAY_MIN_NS * 25 + 999) / 1000;
	localparam int unsigned DELAY_MAX_CYC   = (DELAY_MAX_NS * 25) / 1000;
	localparam int unsigned DELAY_DEF_NS    = 12500;
	localparam int unsigned MISS_LIMIT      = 30;
	localparam int unsigned STAGES          = 8;
	localparam int unsigned AMP_W           = 12;
	// 0.5 V with 1 lsb = 1 mV
	localparam int unsigned THRESH_MV       = 500;
	localparam int unsigned CNT_W           = 10;
	localparam int unsigned MISS_W          = 6;
	// nominal clock acquires after this many detected pulses
	localparam int unsigned ACQ_PULSES      = 2;
endpackage

/* File: hdl/pcms_sync.sv */
// pam clock recovery, delayed data sync and missing-pulse shift register
// assumes video amplitude sampled and baseline-referenced, synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module pcms_sync
	import pcms_pkg::*;
#(
	parameter int unsigned PERIOD   = PERIOD_CYC,
	parameter int unsigned SYNC_DLY = (DELAY_DEF_NS * 25) / 1000,
	parameter int unsigned SAMP_DLY = (DELAY_DEF_NS * 25) / 1000,
	parameter int unsigned MISS_MAX = MISS_LIMIT
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [AMP_W-1:0] video_amp,
	output logic                  clk_square,
	output logic                  clk_pulse,
	output logic                  data_sync,
	output logic                  buf_reset,
	output logic                  miss_pulse,
	output logic                  sync_direct,
	output logic                  sync_delayed,
	output logic                  locked
);
	// refuse settings that the slot timer cannot serve
	if (PERIOD < 4 || PERIOD >= (1 << CNT_W)) begin : g_bad_period
		$error("period out of range");
	end
	// a delay of a whole slot would be restarted by the next rise
	if (SYNC_DLY < DELAY_MIN_CYC || SYNC_DLY > DELAY_MAX_CYC
		|| SYNC_DLY >= PERIOD) begin : g_bad_sync
		$error("sync delay out of range");
	end
	// sampling on the last phase would collide with the slot shift
	if (SAMP_DLY < DELAY_MIN_CYC || SAMP_DLY > DELAY_MAX_CYC
		|| SAMP_DLY + 1 >= PERIOD) begin : g_bad_samp
		$error("sample delay out of range");
	end
	if (MISS_MAX >= (1 << MISS_W) - 1) begin : g_bad_miss
		$error("miss limit too large");
	end
	if (ACQ_PULSES < 1 || ACQ_PULSES > 4) begin : g_bad_acq
		$error("acquisition count out of range");
	end

	localparam logic [CNT_W-1:0]  PER_M1   = CNT_W'(PERIOD - 1);
	localparam logic [CNT_W-1:0]  HALF     = CNT_W'(PERIOD / 2);
	localparam logic [CNT_W-1:0]  SYD      = CNT_W'(SYNC_DLY);
	localparam logic [CNT_W-1:0]  SAD      = CNT_W'(SAMP_DLY);
	localparam logic [MISS_W-1:0] MMAX     = MISS_W'(MISS_MAX);
	localparam logic [AMP_W-1:0]  THR      = AMP_W'(THRESH_MV);
	localparam logic [1:0]        ACQ_LAST = 2'(ACQ_PULSES - 1);

	typedef enum logic [1:0] {
		PCMS_IDLE = 2'b01,
		PCMS_RUN  = 2'b10
	} pcms_state_t;

	// lock state and acquisition count
	pcms_state_t            state_reg;
	pcms_state_t            state_next;
	logic [1:0]             acq_reg;
	logic [1:0]             acq_next;
	// slot timer and data seen in this slot
	logic [CNT_W-1:0]       phase_reg;
	logic [CNT_W-1:0]       phase_next;
	logic                   seen_reg;
	logic                   seen_next;
	// consecutive misses
	logic [MISS_W-1:0]      miss_reg;
	logic [MISS_W-1:0]      miss_next;
	// data sync delay
	logic [CNT_W-1:0]       sdly_reg;
	logic [CNT_W-1:0]       sdly_next;
	logic                   sdly_act_reg;
	logic                   sdly_act_next;
	logic                   ds_reg;
	logic                   ds_next;
	// buffer stage and storage taps
	logic                   buf_reg;
	logic                   buf_next;
	wire logic [STAGES-1:0] sr_tap;
	// registered clock outputs and pulses
	logic                   sq_reg;
	logic                   sq_next;
	logic                   cp_reg;
	logic                   cp_next;
	logic                   br_reg;
	logic                   br_next;
	logic                   mp_reg;
	logic                   mp_next;
	// per-cycle strobes
	logic                   running;
	logic                   idle;
	logic                   present;
	logic                   rise;
	logic                   samp;
	logic                   hit_now;
	logic                   miss_now;
	logic                   first_hit;
	logic                   lock_now;
	logic                   drop;

	// decode of lock state, amplitude and slot phase
	assign running   = (state_reg == PCMS_RUN);
	assign idle      = (state_reg == PCMS_IDLE);
	assign present   = (video_amp >= THR); // R8
	assign rise      = running && (phase_reg == PER_M1);
	assign samp      = running && (phase_reg == SAD); // R10
	assign hit_now   = samp && (present || seen_reg);
	// a pulse seen earlier in the slot still counts, jitter tolerance
	assign miss_now  = samp && !(present || seen_reg); // R7
	assign first_hit = idle && present && !seen_reg;
	assign lock_now  = first_hit && (acq_reg == ACQ_LAST);
	assign drop      = miss_now && (miss_reg == MMAX); // R4

	// lock: pulses in separate slots, loss past the miss limit
	always_comb begin
		state_next = state_reg;
		acq_next   = acq_reg;
		case (state_reg)
			PCMS_IDLE: begin
				if (first_hit) begin
					if (acq_reg == ACQ_LAST) begin
						state_next = PCMS_RUN; // R21
						acq_next   = '0;
					end else begin
						acq_next = acq_reg + 1'b1;
					end
				end
			end
			PCMS_RUN: begin
				if (drop)
					state_next = PCMS_IDLE; // R4
			end
			default: begin
				state_next = PCMS_IDLE;
				acq_next   = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= PCMS_IDLE;
			acq_reg   <= '0;
		end else begin
			state_reg <= state_next;
			acq_reg   <= acq_next;
		end
	end

	// slot timer realigns so an acquired pulse sits at the sample phase
	always_comb begin
		if (phase_reg == PER_M1)
			phase_next = '0;
		else
			phase_next = phase_reg + 1'b1; // R19
		if (first_hit)
			phase_next = SAD + 1'b1;
		seen_next = seen_reg;
		if (present)
			seen_next = 1'b1;
		if (phase_reg == PER_M1)
			seen_next = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_reg <= '0;
			seen_reg  <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			seen_reg  <= seen_next;
		end
	end

	// consecutive miss count, cleared by any detected pulse
	always_comb begin
		miss_next = miss_reg;
		case (state_reg)
			PCMS_RUN: begin
				if (hit_now || drop)
					miss_next = '0; // R20
				else if (miss_now)
					miss_next = miss_reg + 1'b1; // R3 R20
			end
			default: begin
				miss_next = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			miss_reg <= '0;
		else
			miss_reg <= miss_next;
	end

	// delay restarts on every rise so a late end never doubles a pulse
	always_comb begin
		sdly_next     = sdly_reg;
		sdly_act_next = sdly_act_reg;
		ds_next       = 1'b0;
		if (rise) begin
			sdly_next     = '0; // R5
			sdly_act_next = 1'b1;
		end else if (sdly_act_reg) begin
			sdly_next = sdly_reg + 1'b1;
			if (sdly_reg == SYD - 1'b1) begin
				ds_next       = 1'b1; // R2 R5
				sdly_act_next = 1'b0;
			end
		end
		if (drop)
			sdly_act_next = 1'b0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdly_reg     <= '0;
			sdly_act_reg <= 1'b0;
			ds_reg       <= 1'b0;
		end else begin
			sdly_reg     <= sdly_next;
			sdly_act_reg <= sdly_act_next;
			ds_reg       <= ds_next;
		end
	end

	// set wins over the clear; a stale flag is dropped on relock
	always_comb begin
		buf_next = buf_reg;
		if (br_reg || lock_now)
			buf_next = 1'b0; // R9 R14
		if (miss_now)
			buf_next = 1'b1; // R14 R15
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			buf_reg <= 1'b0;
		else
			buf_reg <= buf_next;
	end

	// storage stages move only on the rise, frozen while unlocked
	for (genvar g = 0; g < STAGES; g++) begin : g_stage
		logic stage_in;
		logic stage_reg;
		logic stage_next;
		if (g == 0) begin : g_first
			assign stage_in = buf_reg; // R13 R16
		end else begin : g_rest
			assign stage_in = sr_tap[g-1]; // R16
		end
		always_comb begin
			stage_next = stage_reg;
			if (rise)
				stage_next = stage_in; // R15
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst)
				stage_reg <= 1'b0;
			else
				stage_reg <= stage_next;
		end
		assign sr_tap[g] = stage_reg; // R12
	end

	// single-cycle pulses launched from the slot boundary, the miss pulse from the sample phase
	always_comb begin
		cp_next = rise; // R6
		br_next = rise; // R9
		mp_next = miss_now; // R7 R11
		// square wave high in first half of slot, rising at slot start
		sq_next = (state_next == PCMS_RUN) && (phase_next < HALF); // R1
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sq_reg <= 1'b0;
			cp_reg <= 1'b0;
			br_reg <= 1'b0;
			mp_reg <= 1'b0;
		end else begin
			sq_reg <= sq_next;
			cp_reg <= cp_next;
			br_reg <= br_next;
			mp_reg <= mp_next;
		end
	end

	assign clk_square   = sq_reg; // R1 R6
	assign clk_pulse    = cp_reg; // R6
	assign data_sync    = ds_reg; // R1 R6
	assign buf_reset    = br_reg; // R9
	assign miss_pulse   = mp_reg; // R11
	// direct flag is the detector pulse, delayed is the last storage stage
	assign sync_direct  = mp_reg; // R12 R17
	assign sync_delayed = sr_tap[STAGES-1]; // R12 R13 R17
	assign locked       = running;
endmodule
`default_nettype wire

/* File: verif/pcms_sync_chk.sv */
// port timing checker for pcms_sync
// assumes the bind below reaches every pcms_sync
`timescale 1ns/10ps
`default_nettype none
module pcms_sync_chk #(
	parameter int unsigned SYNC_DLY = 312
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] video_amp,
	input wire logic        clk_square,
	input wire logic        clk_pulse,
	input wire logic        data_sync,
	input wire logic        buf_reset,
	input wire logic        miss_pulse,
	input wire logic        sync_direct,
	input wire logic        sync_delayed,
	input wire logic        locked
);
	// cycles since slot start; wraps past 1023, never reached in a slot
	logic [9:0] since_reg;
	logic [9:0] since_next;
	always_comb since_next = clk_pulse ? 10'h0 : since_reg + 10'h1;
	always_ff @(posedge clk or posedge rst)
		if (rst) since_reg <= 10'h3ff;
		else since_reg <= since_next;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_BUF_RST: assert property (clk_pulse |-> ##[0:1] buf_reset)
		else $error("buffer reset missing");
	AST_SYNC_DLY: assert property (data_sync |-> since_reg == SYNC_DLY - 1)
		else $error("data sync off its delay");
	AST_DIRECT: assert property (sync_direct == miss_pulse)
		else $error("direct flag differs");
	AST_IDLE: assert property (!locked && !$past(locked) |-> !clk_pulse)
		else $error("clock while stopped");
	AST_PULSE_ONE: assert property (clk_pulse |=> !clk_pulse)
		else $error("clock pulse too long");
	AST_MISS_ONE: assert property (miss_pulse |=> !miss_pulse)
		else $error("miss pulse too long");
	AST_SQ_RISE: assert property (clk_pulse |-> ##[0:1] clk_square)
		else $error("square wave not high");
	AST_DLY_STEP: assert property ($changed(sync_delayed) |->
		clk_pulse || since_reg == 10'h0)
		else $error("delayed flag moved mid slot");
endmodule
bind pcms_sync pcms_sync_chk #(.SYNC_DLY(SYNC_DLY)) i_chk (.clk(clk),
	.rst(rst), .video_amp(video_amp), .clk_square(clk_square),
	.clk_pulse(clk_pulse), .data_sync(data_sync), .buf_reset(buf_reset),
	.miss_pulse(miss_pulse), .sync_direct(sync_direct),
	.sync_delayed(sync_delayed), .locked(locked));
`default_nettype wire

/* File: verif/pcms_coin.sv */
// downstream coincidence gate model
// assumes flags from pcms_sync on the same clock
`timescale 1ns/10ps
`default_nettype none
module pcms_coin (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sync_direct,
	input  wire logic sync_delayed,
	output logic      coin_pulse
);
	always_ff @(posedge clk or posedge rst)
		if (rst) coin_pulse <= 1'b0;
		else coin_pulse <= sync_direct & sync_delayed;
endmodule
`default_nettype wire

/* File: verif/pcms_sync_test.sv */
// self-checking bench for pcms_sync
// assumes default parameters, 625-cycle slots
`timescale 1ns/10ps
`default_nettype none
module pcms_sync_test;
	import pcms_pkg::*;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic [AMP_W-1:0] video_amp = '0;
	logic             sq, cp, ds, br, mp, sd, sl, lk, coin;
	int n_errors = 0, n_tests = 0, seed = 32'hb3a1748b;
	int n_miss = 0, n_dly = 0, n_coin = 0, n_lost = 0, m, d, c, l;
	int pend = 0;
	int e_sl;
	int hist[$];
	always #20 clk = ~clk;
	pcms_sync i_dut (.clk(clk), .rst(rst), .video_amp(video_amp),
		.clk_square(sq), .clk_pulse(cp), .data_sync(ds), .buf_reset(br),
		.miss_pulse(mp), .sync_direct(sd), .sync_delayed(sl), .locked(lk));
	pcms_coin i_coin (.clk(clk), .rst(rst), .sync_direct(sd),
		.sync_delayed(sl), .coin_pulse(coin));
	// counted off the edge so stimulus never races the tally
	always @(negedge clk) begin
		n_miss += (mp === 1'b1);
		n_dly += (sl === 1'b1);
		n_coin += (coin === 1'b1);
		n_lost += (lk !== 1'b1);
	end
	// storage chain model: one flag per shift, frozen while unlocked
	always @(negedge clk)
		if (cp === 1'b1) begin
			hist.push_back(pend);
			e_sl = (hist.size() >= 8) ? hist[hist.size() - 8] : 0;
			chk("stored flag", e_sl, sl);
		end
	task automatic chk(input string what, input int exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s exp %0d got %0d", what, exp, got);
			n_errors++;
		end
	endtask
	// pulse near slot start; noise stays under threshold, 499 included
	task slot(input bit present);
		pend = !present;
		for (int i = 0; i < 625; i++) begin
			@(posedge clk);
			if (present && i >= 100 && i < 104)
				video_amp <= 12'h1f4 + 12'($unsigned($random(seed)) % 3000);
			else video_amp <= 12'($unsigned($random(seed)) % 500);
		end
	endtask
	task snap;
		m = n_miss; d = n_dly; c = n_coin; l = n_lost;
	endtask
	task stop_test;
		$display("counts %0d compares %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (6) slot(1);
		chk("locked", 1, lk);
		snap;
		slot(0);
		repeat (7) slot(1);
		slot(0);
		repeat (10) slot(1);
		chk("misses", 2, n_miss - m);
		chk("delayed cycles", 1250, n_dly - d);
		chk("coincidences", 1, n_coin - c);
		$display("test shift done");
		snap;
		repeat (30) slot(0);
		repeat (4) slot(1);
		chk("unlocked cycles", 0, n_lost - l);
		chk("misses", 30, n_miss - m);
		$display("test gap done");
		repeat (32) slot(0);
		chk("locked", 0, lk);
		repeat (6) slot(1);
		chk("locked", 1, lk);
		$display("test loss done");
		stop_test;
	end
	initial begin
		// tests take about 60700 cycles; stop a hang at 70000
		#2800000;
		n_errors++;
		stop_test;
	end
endmodule
`default_nettype wire
